// file: rtl/sfx_pkg.sv
// Constants and carrier types for the SFR address extension block.
// Assumes a single core clock and an 8051-style SFR access port.
// Function
// - Decode SFR accesses only in 80h-FFh.
// - Standard and mapped areas give 256 registers.
// - Map-select bit 0 at 8Fh picks area.
// - Map-select holds until software clears it.
// - Control bit 2 reads back last written.
// - Other control bits read zero; reset 00h.
// - Paged peripheral access follows its page field.
// - Each peripheral sets own page count.
// - Four storage slots selected per write.
// - Save write stores old page, loads new.
// - Restore write loads slot, ignores data.
// - Paging for ports, ADC, capture, system.
// - Page field bits 2-0, reads active page.
// - Slot number field in bits 5-4.
// - Operation 0X direct, 10 save, 11 restore.
// - Page register resets 00h, bit3 zero.
package sfx_pkg;
  localparam logic [7:0] SFR_LO      = 8'h80;
  localparam logic [7:0] ADDR_SYSCON = 8'h8F;
  localparam logic [7:0] SYSCON_RST  = 8'h00;
  localparam logic [7:0] PAGE_RST    = 8'h00;
  localparam int         N_MODULES   = 4;
  localparam int         N_SLOTS     = 4;
  localparam int         MAP_BIT     = 0;
  localparam int         KEEP_BIT    = 2;
  // Control bits that have storage: map select and the keep bit.
  localparam logic [7:0] CTRL_WR_MASK = 8'h05;
  // Page register addresses, one per paged module (standard area).
  localparam logic [7:0] ADDR_PG_PORT = 8'hB2;
  localparam logic [7:0] ADDR_PG_ADC  = 8'hD1;
  localparam logic [7:0] ADDR_PG_CCU  = 8'hA3;
  localparam logic [7:0] ADDR_PG_SYS  = 8'h9F;
  localparam logic [1:0] MOD_PORT = 2'h0;
  localparam logic [1:0] MOD_ADC  = 2'h1;
  localparam logic [1:0] MOD_CCU  = 2'h2;
  localparam logic [1:0] MOD_SYS  = 2'h3;

  typedef enum logic [1:0] {
    SFX_OP_DIR0    = 2'b00,
    SFX_OP_DIR1    = 2'b01,
    SFX_OP_SAVE    = 2'b10,
    SFX_OP_RESTORE = 2'b11
  } sfx_op_t;

  // Write image of a page register.
  typedef struct packed {
    sfx_op_t    page_operation;
    logic [1:0] storage_slot_number;
    logic       rsvd;
    logic [2:0] page;
  } sfx_page_wr_t;

  // Decoded access towards the peripheral registers.
  typedef struct packed {
    logic       valid;
    logic       mapped;
    logic [6:0] offset;
    logic [2:0] page;
  } sfx_route_t;
endpackage : sfx_pkg

// file: rtl/sfx_page_unit.sv
// One module page register with its four storage slots.
// Assumes writes come as one-cycle strobes from the SFR decoder.
`timescale 1ns/1ps
`default_nettype none
module sfx_page_unit (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 wr_en,
  input  wire sfx_pkg::sfx_page_wr_t wdata,
  output logic [2:0]                page_q
);
  logic [2:0] slot_q [sfx_pkg::N_SLOTS];
  logic [2:0] page_d;
  wire        is_save = wr_en && wdata.page_operation == sfx_pkg::SFX_OP_SAVE;
  wire        is_rest = wr_en &&
                        wdata.page_operation == sfx_pkg::SFX_OP_RESTORE;

  always_comb begin
    page_d = page_q;
    if (is_rest) begin
      page_d = slot_q[wdata.storage_slot_number];
    end else if (wr_en) begin
      page_d = wdata.page;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      page_q <= sfx_pkg::PAGE_RST[2:0];
    end else begin
      page_q <= page_d;
    end
  end

  // save old page
  // Only the save path writes a slot, so slots are not software-addressable.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < sfx_pkg::N_SLOTS; i++) begin
        slot_q[i] <= 3'h0;
      end
    end else if (is_save) begin
      slot_q[wdata.storage_slot_number] <= page_q;
    end
  end

  chk_save_stores_page: assert property (
    @(posedge mclk) disable iff (!rst_b)
    is_save |=> slot_q[$past(wdata.storage_slot_number)] == $past(page_q)
      && page_q == $past(wdata.page))
    else $error("Save write did not store old page and load new one.");
  chk_restore_loads_slot: assert property (
    @(posedge mclk) disable iff (!rst_b)
    is_rest |=> page_q == $past(slot_q[wdata.storage_slot_number]))
    else $error("Restore write did not load the selected slot.");
  chk_page_holds_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !wr_en |=> $stable(page_q))
    else $error("Page changed without a write.");
  chk_slot_untouched_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (wr_en && !is_save) |=> slot_q[0] == $past(slot_q[0])
      && slot_q[1] == $past(slot_q[1]) && slot_q[2] == $past(slot_q[2])
      && slot_q[3] == $past(slot_q[3]))
    else $error("Storage slot changed on a non-save write.");
endmodule : sfx_page_unit
`default_nettype wire

// file: rtl/sfx_addr_ext.sv
// SFR address extension: map-select register and four module pagers.
// Assumes the CPU core gives one-cycle SFR read/write strobes on mclk.
`timescale 1ns/1ps
`default_nettype none
module sfx_addr_ext (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata_q,
  output logic             sfr_hit_q,
  output logic             sfr_map_select,
  output sfx_pkg::sfx_route_t route_q,
  output logic [11:0]      module_pages_q
);
  logic [7:0]  ctrl_q;
  logic [2:0]  page_w [sfx_pkg::N_MODULES];
  logic [3:0]  pg_wr;
  logic [1:0]  pg_idx;
  logic        pg_hit;

  // only the upper half of direct space is SFR space.
  wire in_sfr   = sfr_addr >= sfx_pkg::SFR_LO;
  wire acc      = (sfr_wr || sfr_rd) && in_sfr;
  // area comes from the control bit, not the instruction.
  wire mapped   = ctrl_q[sfx_pkg::MAP_BIT];
  // Control register is reachable from both areas, like CPU registers.
  wire ctrl_hit = in_sfr && sfr_addr == sfx_pkg::ADDR_SYSCON;
  wire ctrl_wr  = sfr_wr && ctrl_hit;

  // page registers for the four paged modules, standard area.
  always_comb begin
    pg_hit = !mapped && in_sfr;
    pg_idx = sfx_pkg::MOD_PORT;
    unique case (sfr_addr)
      sfx_pkg::ADDR_PG_PORT: pg_idx = sfx_pkg::MOD_PORT;
      sfx_pkg::ADDR_PG_ADC:  pg_idx = sfx_pkg::MOD_ADC;
      sfx_pkg::ADDR_PG_CCU:  pg_idx = sfx_pkg::MOD_CCU;
      sfx_pkg::ADDR_PG_SYS:  pg_idx = sfx_pkg::MOD_SYS;
      default:               pg_hit = 1'b0;
    endcase
  end

  assign pg_wr = (sfr_wr && pg_hit) ? (4'h1 << pg_idx) : 4'h0;

  // each module owns its pager with four slots.
  for (genvar m = 0; m < sfx_pkg::N_MODULES; m++) begin : g_pg
    sfx_page_unit u_pg (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .wr_en  (pg_wr[m]),
      .wdata  (sfx_pkg::sfx_page_wr_t'(sfr_wdata)),
      .page_q (page_w[m])
    );
  end

  // keep bits 0 and 2, others read zero
  // Only the map-select and keep bits have storage; the mask drops the
  // reserved bits at the write, so a read needs no masking of its own.
  wire [7:0] ctrl_d = ctrl_wr ? (sfr_wdata & sfx_pkg::CTRL_WR_MASK)
                              : ctrl_q;

  // hardware never clears map-select on its own.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= sfx_pkg::SYSCON_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Module of the paged register window, taken from address bits 6-5.
  // each peripheral uses as many pages as it decodes.
  wire [1:0] tgt_mod = sfr_addr[6:5];

  // page register reads expose only the active page.
  wire [7:0] rd_mux = ctrl_hit ? ctrl_q :
                      pg_hit   ? {5'h00, page_w[pg_idx]} : 8'h00;

  // routed access carries the owning module's page.
  // mapped flag doubles the decoded space.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q    <= 8'h00;
      sfr_hit_q      <= 1'b0;
      sfr_map_select <= 1'b0;
      route_q        <= '0;
      module_pages_q <= 12'h000;
    end else begin
      sfr_rdata_q    <= sfr_rd ? rd_mux : 8'h00;
      sfr_hit_q      <= acc;
      sfr_map_select <= ctrl_d[sfx_pkg::MAP_BIT];
      route_q        <= '{valid: acc, mapped: mapped,
                          offset: sfr_addr[6:0], page: page_w[tgt_mod]};
      module_pages_q <= {page_w[3], page_w[2], page_w[1], page_w[0]};
    end
  end

  // Checks on the decoder, one rule each. Behaviours with several steps
  // are built from the named sequences so that the steps read in order.

  // Any decoded access in the upper half of direct space.
  sequence s_sfr_access;
    acc;
  endsequence

  // A write that lands on one of the page registers.
  sequence s_page_write;
    sfr_wr && pg_hit;
  endsequence

  // A control write followed by one cycle without any write.
  sequence s_ctrl_write;
    ctrl_wr ##1 !sfr_wr;
  endsequence

  // A read of the control register, from either area.
  sequence s_ctrl_read;
    sfr_rd && ctrl_hit;
  endsequence

  chk_ctrl_reserved_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ctrl_q & ~sfx_pkg::CTRL_WR_MASK) == 8'h00)
    else $error("Reserved control bits are not zero.");

  chk_keep_bit_readback: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ctrl_wr |=>
      ctrl_q[sfx_pkg::KEEP_BIT] == $past(sfr_wdata[sfx_pkg::KEEP_BIT]))
    else $error("Control bit 2 did not keep the written value.");

  chk_ctrl_readback: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_ctrl_write ##1 s_ctrl_read |=>
      sfr_rdata_q == ($past(sfr_wdata, 3) & sfx_pkg::CTRL_WR_MASK))
    else $error("Control register did not read back the stored bits.");

  chk_map_sticky: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (mapped && !ctrl_wr) |=> mapped)
    else $error("Map select cleared without a write.");

  chk_ctrl_holds_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("Control register changed without a write.");

  chk_map_out_mirror: assert property (
    @(posedge mclk) disable iff (!rst_b)
    sfr_map_select == ctrl_q[sfx_pkg::MAP_BIT])
    else $error("Map select output differs from the control bit.");

  chk_area_follows_bit: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_sfr_access |=> route_q.mapped == $past(mapped) && route_q.valid)
    else $error("Access routed to the wrong area.");

  chk_low_addr_ignored: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sfr_addr < sfx_pkg::SFR_LO) |=> !sfr_hit_q && !route_q.valid)
    else $error("Access below SFR space was decoded.");

  chk_hit_needs_strobe: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(sfr_wr || sfr_rd) |=> !sfr_hit_q && !route_q.valid)
    else $error("Access reported without a strobe.");

  chk_rdata_outside_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(sfr_rd && in_sfr) |=> sfr_rdata_q == 8'h00)
    else $error("Read data seen without a decoded read.");

  chk_mapped_page_refused: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sfr_wr && mapped) |-> pg_wr == 4'h0)
    else $error("Mapped access wrote a standard page register.");

  chk_route_offset: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_sfr_access |=> route_q.offset == $past(sfr_addr[6:0]))
    else $error("Routed offset differs from the access address.");

  chk_page_write_strobe: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_page_write |-> $onehot(pg_wr))
    else $error("Page write did not reach exactly one pager.");

  chk_pages_follow_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_page_write |-> ##2 module_pages_q == $past({page_w[3], page_w[2],
      page_w[1], page_w[0]}))
    else $error("Page outputs did not follow the page registers.");

  chk_page_read_masked: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sfr_rd && pg_hit) |=> sfr_rdata_q[7:3] == 5'h00)
    else $error("Page register read exposed write-only fields.");

  chk_page_read_value: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (sfr_rd && pg_hit) |=> sfr_rdata_q[2:0] == $past(page_w[pg_idx]))
    else $error("Page register read did not give the active page.");

  chk_route_page: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_sfr_access |=> route_q.page == $past(page_w[tgt_mod]))
    else $error("Routed access carried the wrong page.");
endmodule : sfx_addr_ext
`default_nettype wire

// file: tb/sfx_cpu_model.sv
// Core-side model that issues SFR byte reads and writes.
// Assumes the block samples strobes on the rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module sfx_cpu_model (
  input  wire logic       mclk,
  input  wire logic [7:0] sfr_rdata_q,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata
);
  // Idle bus at time zero.
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // Released data is inverted so stale bytes never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr
  // Read data lands one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1 d = sfr_rdata_q;
  endtask : rd
  task automatic set_map(input logic on);
    logic [7:0] v;
    rd(sfx_pkg::ADDR_SYSCON, v);
    wr(sfx_pkg::ADDR_SYSCON, on ? (v | 8'h01) : (v & 8'hFE));
  endtask : set_map
endmodule : sfx_cpu_model
`default_nettype wire

// file: tb/sfx_addr_ext_tb.sv
// Self-checking bench for the SFR address extension block.
// Assumes the partner model drives all bus inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module sfx_addr_ext_tb;
  logic mclk, rst_b, sfr_wr, sfr_rd, sfr_hit_q, sfr_map_select;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, v;
  sfx_pkg::sfx_route_t route_q;
  logic [11:0] module_pages_q;
  int n_mismatch, compares;
  logic [31:0] seed = 32'h4743;
  logic [31:0] r;
  logic [2:0] pg[4];
  logic [2:0] st[4][4];
  logic [7:0] pa[4] = '{sfx_pkg::ADDR_PG_PORT, sfx_pkg::ADDR_PG_ADC,
                        sfx_pkg::ADDR_PG_CCU, sfx_pkg::ADDR_PG_SYS};
  logic [7:0] ops[4] = '{8'h05, 8'h9B, 8'h42, 8'hD6};
  sfx_addr_ext i_sfx_addr_ext (.mclk(mclk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .sfr_hit_q(sfr_hit_q), .sfr_map_select(sfr_map_select),
    .route_q(route_q), .module_pages_q(module_pages_q));
  sfx_cpu_model i_sfx_cpu_model (.mclk(mclk), .sfr_rdata_q(sfr_rdata_q),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Restore takes the slot and drops the written page.
  function automatic logic [2:0] nxt(input logic [7:0] d, input int m);
    return (d[7:6] == 2'b11) ? st[m][d[5:4]] : d[2:0];
  endfunction : nxt
  // Page write, then readback, state outputs and routing.
  task automatic pw(input int m, input logic [7:0] d);
    logic [2:0] e;
    e = nxt(d, m);
    if (d[7:6] == 2'b10) st[m][d[5:4]] = pg[m];
    pg[m] = e;
    i_sfx_cpu_model.wr(pa[m], d);
    i_sfx_cpu_model.rd(pa[m], v);
    `CHK("page", {5'h00, pg[m]}, v)
    `CHK("pages", pg[m], module_pages_q[3*m+:3])
    `CHK("route", pg[pa[m][6:5]], route_q.page)
    `CHK("route off", pa[m][6:0], route_q.offset)
    `CHK("route area", 1'b0, route_q.mapped)
    `CHK("hit", 1'b1, sfr_hit_q)
  endtask : pw
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Free-running core clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Hang guard, far beyond the expected run.
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence: reset values with one restore per module, mapping, then paging.
  initial begin
    rst_b = 1'b0;
    n_mismatch = 0;
    compares = 0;
    pg = '{default: 3'h0};
    st = '{default: '{default: 3'h0}};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    i_sfx_cpu_model.rd(sfx_pkg::ADDR_SYSCON, v);
    `CHK("ctrl rst", 8'h00, v)
    for (int m = 0; m < 4; m++) begin
      i_sfx_cpu_model.rd(pa[m], v);
      `CHK("page rst", 8'h00, v)
      pw(m, 8'hF7);
    end
    i_sfx_cpu_model.wr(sfx_pkg::ADDR_SYSCON, 8'hFF);
    i_sfx_cpu_model.rd(sfx_pkg::ADDR_SYSCON, v);
    `CHK("ctrl", 8'h05, v)
    i_sfx_cpu_model.wr(pa[0], 8'h07);
    repeat (20) @(posedge mclk);
    `CHK("map held", 1'b1, sfr_map_select)
    `CHK("mapped pg", 3'h0, module_pages_q[2:0])
    i_sfx_cpu_model.rd(pa[0], v);
    `CHK("mapped rd", 8'h00, v)
    `CHK("mapped hit", 1'b1, route_q.valid)
    `CHK("mapped area", 1'b1, route_q.mapped)
    i_sfx_cpu_model.set_map(1'b0);
    #1 `CHK("map clr", 1'b0, sfr_map_select)
    i_sfx_cpu_model.wr(8'h0F, 8'h01);
    i_sfx_cpu_model.rd(8'h0F, v);
    `CHK("low hit", 1'b0, sfr_hit_q)
    `CHK("low map", 1'b0, sfr_map_select)
    for (int i = 0; i < 4; i++) pw(0, ops[i]);
    repeat (80) begin
      r = xs();
      pw(int'(r[1:0]), r[15:8]);
    end
    report_and_stop();
  end
endmodule : sfx_addr_ext_tb
`default_nettype wire
